//--- osc_pkg.sv
// constants and types shared by the oscillator control and output stage
package osc_pkg;
   localparam int unsigned ADDR_W      = 12;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned INC_W       = 16;
   localparam int unsigned CNT_W       = 8;
   localparam int unsigned PWS_W       = 3;
   localparam int unsigned CKS_W       = 2;

   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] CLKW_OFFSET = 12'h004;
   localparam logic [11:0] INC_OFFSET  = 12'h008;

   localparam int unsigned EN_BIT      = 7;
   localparam int unsigned OE_BIT      = 6;
   localparam int unsigned LEVEL_BIT   = 5;
   localparam int unsigned POL_BIT     = 4;
   localparam int unsigned PFM_BIT     = 0;
   localparam int unsigned PWS_LSB     = 5;
   localparam int unsigned CKS_LSB     = 0;

   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [7:0]  CLKW_RESET  = 8'h00;
   localparam logic [15:0] INC_RESET   = 16'h0000;

   typedef enum logic [1:0] {
      SRC_EXT  = 2'h0,
      SRC_SYS  = 2'h1,
      SRC_FAST = 2'h2,
      SRC_CELL = 2'h3
   } clk_src_type;

   typedef enum logic {
      PS_LOW  = 1'h0,
      PS_HIGH = 1'h1
   } pulse_state_type;
endpackage : osc_pkg

//--- osc_link.sv
// link between the register stage, the clock picker and the pulse shaper
`timescale 1ns/100ps
`default_nettype none
interface osc_link;
   import osc_pkg::*;
   clk_src_type        clk_sel;
   logic               tick;
   logic               overflow;
   logic               enable;
   logic               pfm;
   logic [PWS_W-1:0]   pws;
   logic               level;

   modport picker (input clk_sel, output tick);
   modport shaper (input tick, overflow, enable, pfm, pws, output level);
   modport top    (output clk_sel, overflow, enable, pfm, pws,
                   input tick, level);
endinterface : osc_link
`default_nettype wire

//--- clock_picker.sv
// selects one of four clock sources and makes a tick on its rising edge
`timescale 1ns/100ps
`default_nettype none
module clock_picker (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic logic_cell_one_output,
   input  wire logic internal_fast_oscillator,
   input  wire logic system_clock_source,
   input  wire logic external_osc_clock_pin,
   osc_link.picker   lnk
);
   import osc_pkg::*;

   typedef struct packed {
      logic prev;
      logic tick;
   } picker_state_type;

   picker_state_type cur_reg;
   picker_state_type cur_next;
   logic             src;

   // ***********************************************
   // source select and edge detect
   // ***********************************************
   always_comb begin
      unique case (lnk.clk_sel)
         SRC_CELL: src = logic_cell_one_output;
         SRC_FAST: src = internal_fast_oscillator;
         SRC_SYS:  src = system_clock_source;
         SRC_EXT:  src = external_osc_clock_pin;
      endcase
      cur_next      = cur_reg;
      cur_next.prev = src;
      cur_next.tick = src & ~cur_reg.prev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_reg <= '0;
      end else if (ce) begin
         cur_reg <= cur_next;
      end
   end

   assign lnk.tick = cur_reg.tick;

   chk_tick_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && src && !cur_reg.prev) |=> lnk.tick)
      else $error("no tick on rising edge of selected source");
endmodule : clock_picker
`default_nettype wire

//--- pulse_shaper.sv
// shapes the oscillator level in fixed duty or pulse frequency mode
`timescale 1ns/100ps
`default_nettype none
module pulse_shaper (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   osc_link.shaper   lnk
);
   import osc_pkg::*;

   typedef struct packed {
      pulse_state_type   st;
      logic [CNT_W-1:0]  cnt;
   } shaper_state_type;

   shaper_state_type cur_reg;
   shaper_state_type cur_next;

   // ***********************************************
   // level and width counter
   // ***********************************************
   always_comb begin
      cur_next = cur_reg;
      if (!lnk.enable) begin
         cur_next.st  = PS_LOW;
         cur_next.cnt = '0;
      end else if (!lnk.pfm) begin
         cur_next.cnt = '0;
         if (lnk.tick && lnk.overflow) begin
            unique case (cur_reg.st)
               PS_LOW:  cur_next.st = PS_HIGH;
               PS_HIGH: cur_next.st = PS_LOW;
            endcase
         end
      end else if (lnk.tick) begin
         if (lnk.overflow) begin
            cur_next.st  = PS_HIGH;
            cur_next.cnt = CNT_W'((8'h01 << lnk.pws) - 8'h01);
         end else if (cur_reg.st == PS_HIGH) begin
            if (cur_reg.cnt == '0) begin
               cur_next.st = PS_LOW;
            end else begin
               cur_next.cnt = cur_reg.cnt - 8'h01;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_reg <= '0;
      end else if (ce) begin
         cur_reg <= cur_next;
      end
   end

   assign lnk.level = (cur_reg.st == PS_HIGH);

   chk_off_when_off: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !lnk.enable) |=> !lnk.level)
      else $error("level high while module is off");

   chk_fixed_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && lnk.enable && !lnk.pfm && lnk.tick && lnk.overflow)
      |=> (lnk.level != $past(lnk.level)))
      else $error("fixed duty level did not toggle on overflow");

   chk_pulse_load: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && lnk.enable && lnk.pfm && lnk.tick && lnk.overflow)
      |=> (lnk.level && cur_reg.cnt == CNT_W'((8'h01 << $past(lnk.pws)) - 8'h01)))
      else $error("pulse start or width load wrong");

   chk_width_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !lnk.pfm) |=> (cur_reg.cnt == '0))
      else $error("width counter active in fixed duty mode");
endmodule : pulse_shaper
`default_nettype wire

//--- nco_control_output.sv
// register stage, accumulator and output pin of the oscillator
//
// Behaviour
// - read-only bit shows current output level
// - polarity bit one inverts the output
// - mode bit one selects pulse frequency mode
// - pulse width is two to the field periods
// - clock select field picks one of four sources
// - width field only used in pulse mode
// - unimplemented control bits read as zero
`timescale 1ns/100ps
`default_nettype none
module nco_control_output (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       ce,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [osc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [osc_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                 pstrb,
   output var  logic [osc_pkg::DATA_W-1:0] prdata,
   output var  logic                       pready,
   output var  logic                       pslverr,
   input  wire logic                       logic_cell_one_output,
   input  wire logic                       internal_fast_oscillator,
   input  wire logic                       system_clock_source,
   input  wire logic                       external_osc_clock_pin,
   output var  logic                       osc_pin_o,
   output var  logic                       osc_pin_oe
);
   import osc_pkg::*;

   typedef struct packed {
      logic               osc_module_on;
      logic               osc_pin_drive_on;
      logic               osc_invert_select;
      logic               pulse_freq_mode_select;
      logic [PWS_W-1:0]   pulse_width_field;
      clk_src_type        osc_clock_source_field;
      logic [INC_W-1:0]   inc;
      logic [INC_W-1:0]   acc;
      logic               pin_o;
      logic               pin_oe;
      logic [DATA_W-1:0]  rdata;
      logic               rd_ready;
   } top_state_type;

   localparam top_state_type TOP_RESET = '{
      osc_module_on:          CTRL_RESET[EN_BIT],
      osc_pin_drive_on:       CTRL_RESET[OE_BIT],
      osc_invert_select:      CTRL_RESET[POL_BIT],
      pulse_freq_mode_select: CTRL_RESET[PFM_BIT],
      pulse_width_field:      CLKW_RESET[PWS_LSB +: PWS_W],
      osc_clock_source_field: clk_src_type'(CLKW_RESET[CKS_LSB +: CKS_W]),
      inc:                    INC_RESET,
      acc:                    16'h0000,
      pin_o:                  1'h0,
      pin_oe:                 1'h0,
      rdata:                  32'h0000_0000,
      rd_ready:               1'h0
   };

   top_state_type      cur_reg;
   top_state_type      cur_next;
   logic [INC_W:0]     sum;
   logic               hit;
   logic               wr_en;
   logic [7:0]         ctrl_view;
   logic [7:0]         clkw_view;
   logic [DATA_W-1:0]  rd_mux;

   osc_link lnk ();

   // ***********************************************
   // sub-blocks
   // ***********************************************
   clock_picker u_picker (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .ce                       (ce),
      .logic_cell_one_output    (logic_cell_one_output),
      .internal_fast_oscillator (internal_fast_oscillator),
      .system_clock_source      (system_clock_source),
      .external_osc_clock_pin   (external_osc_clock_pin),
      .lnk                      (lnk.picker)
   );

   pulse_shaper u_shaper (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .lnk     (lnk.shaper)
   );

   assign lnk.clk_sel  = cur_reg.osc_clock_source_field;
   assign lnk.enable   = cur_reg.osc_module_on;
   assign lnk.pfm      = cur_reg.pulse_freq_mode_select;
   assign lnk.pws      = cur_reg.pulse_width_field;
   assign sum          = {1'h0, cur_reg.acc} + {1'h0, cur_reg.inc};
   assign lnk.overflow = lnk.tick & sum[INC_W];

   // ***********************************************
   // apb decode and read view
   // ***********************************************
   always_comb begin
      ctrl_view            = 8'h00;
      ctrl_view[EN_BIT]    = cur_reg.osc_module_on;
      ctrl_view[OE_BIT]    = cur_reg.osc_pin_drive_on;
      ctrl_view[LEVEL_BIT] = cur_reg.pin_o;
      ctrl_view[POL_BIT]   = cur_reg.osc_invert_select;
      ctrl_view[PFM_BIT]   = cur_reg.pulse_freq_mode_select;
      clkw_view            = 8'h00;
      clkw_view[PWS_LSB +: PWS_W] = cur_reg.pulse_width_field;
      clkw_view[CKS_LSB +: CKS_W] = cur_reg.osc_clock_source_field;
      hit    = 1'h1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         CTRL_OFFSET: rd_mux[7:0]       = ctrl_view;
         CLKW_OFFSET: rd_mux[7:0]       = clkw_view;
         INC_OFFSET:  rd_mux[INC_W-1:0] = cur_reg.inc;
         default:     hit               = 1'h0;
      endcase
   end

   assign pready  = psel & penable & ce & cur_reg.rd_ready;
   assign pslverr = pready & ~hit;
   assign prdata  = cur_reg.rdata;
   assign wr_en   = pready & pwrite & hit;

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      cur_next          = cur_reg;
      cur_next.rd_ready = psel & ~pready;
      if (psel) begin
         cur_next.rdata = rd_mux;
      end
      if (wr_en && paddr == CTRL_OFFSET && pstrb[0]) begin
         cur_next.osc_module_on          = pwdata[EN_BIT];
         cur_next.osc_pin_drive_on       = pwdata[OE_BIT];
         cur_next.osc_invert_select      = pwdata[POL_BIT];
         cur_next.pulse_freq_mode_select = pwdata[PFM_BIT];
      end
      if (wr_en && paddr == CLKW_OFFSET && pstrb[0]) begin
         cur_next.pulse_width_field      = pwdata[PWS_LSB +: PWS_W];
         cur_next.osc_clock_source_field =
            clk_src_type'(pwdata[CKS_LSB +: CKS_W]);
      end
      if (wr_en && paddr == INC_OFFSET) begin
         if (pstrb[0]) begin
            cur_next.inc[7:0] = pwdata[7:0];
         end
         if (pstrb[1]) begin
            cur_next.inc[15:8] = pwdata[15:8];
         end
      end
      if (!cur_reg.osc_module_on) begin
         cur_next.acc = '0;
      end else if (lnk.tick) begin
         cur_next.acc = sum[INC_W-1:0];
      end
      cur_next.pin_o  = lnk.level ^ cur_reg.osc_invert_select;
      cur_next.pin_oe = cur_reg.osc_module_on
                      & cur_reg.osc_pin_drive_on;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_reg <= TOP_RESET;
      end else if (ce) begin
         cur_reg <= cur_next;
      end
   end

   assign osc_pin_o  = cur_reg.pin_o;
   assign osc_pin_oe = cur_reg.pin_oe;

   // ***********************************************
   // checks
   // ***********************************************
   chk_acc_held_off: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !cur_reg.osc_module_on) |=> (cur_reg.acc == '0))
      else $error("accumulator moved while module is off");

   chk_level_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && psel && paddr == CTRL_OFFSET)
      |=> (prdata[LEVEL_BIT] == $past(cur_reg.pin_o)))
      else $error("readback bit does not follow output level");

   chk_pin_polarity: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> (osc_pin_o == ($past(lnk.level) ^ $past(cur_reg.osc_invert_select))))
      else $error("pin level does not follow polarity");

   chk_ctrl_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && psel && paddr == CTRL_OFFSET)
      |=> (prdata[3:1] == 3'h0 && prdata[31:8] == 24'h00_0000))
      else $error("unused control bits read nonzero");

   chk_clkw_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && psel && paddr == CLKW_OFFSET)
      |=> (prdata[4:2] == 3'h0 && prdata[31:8] == 24'h00_0000))
      else $error("unused clock register bits read nonzero");

   chk_pin_enable: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> (osc_pin_oe == ($past(cur_reg.osc_module_on)
                             && $past(cur_reg.osc_pin_drive_on))))
      else $error("pin enable does not follow enable bits");

   chk_sel_written: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && ce && paddr == CLKW_OFFSET && pstrb[0])
      |=> (lnk.clk_sel == $past(pwdata[CKS_LSB +: CKS_W])))
      else $error("clock select not taken from write");
endmodule : nco_control_output
`default_nettype wire

//--- pin_load.sv
// pin load model: a released pin falls to its pull-down level
`timescale 1ns/100ps
`default_nettype none
module pin_load (
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output var  logic pin_level
);
   // ********************
   // pin resolution
   // ********************
   always_comb begin
      pin_level = pin_oe ? pin_o : 1'b0;
   end
endmodule : pin_load
`default_nettype wire

//--- nco_control_output_tb.sv
// self-checking bench for the oscillator control and output stage
`timescale 1ns/100ps
`default_nettype none
module nco_control_output_tb;
   import osc_pkg::*;
   // ********************
   // signals
   // ********************
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic [3:0]        src = 4'h0;
   logic [3:0]        mask = 4'h0;
   logic              div = 1'b0;
   logic              osc_pin_o;
   logic              osc_pin_oe;
   logic              pin_level;
   logic [31:0]       rd;
   logic [31:0]       len;
   logic              er;
   int                err_count = 0;
   int                n_checks = 0;
   int                cyc = 0;

   always #20 pclk = ~pclk;

   // source toggles every 2 cycles, rises every 4
   always @(posedge pclk) begin
      div <= ~div;
      if (div) begin
         src <= src ^ mask;
      end
   end

   nco_control_output nco_control_output_i (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .ce                       (1'b1),
      .psel                     (psel),
      .penable                  (penable),
      .pwrite                   (pwrite),
      .paddr                    (paddr),
      .pwdata                   (pwdata),
      .pstrb                    (4'hF),
      .prdata                   (prdata),
      .pready                   (pready),
      .pslverr                  (pslverr),
      .logic_cell_one_output    (src[3]),
      .internal_fast_oscillator (src[2]),
      .system_clock_source      (src[1]),
      .external_osc_clock_pin   (src[0]),
      .osc_pin_o                (osc_pin_o),
      .osc_pin_oe               (osc_pin_oe)
   );

   pin_load pin_load_i (
      .pin_o     (osc_pin_o),
      .pin_oe    (osc_pin_oe),
      .pin_level (pin_level)
   );

   // ********************
   // tasks
   // ********************
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_count++;
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask : rdc

   // length of the next high pulse on the output, 0 if none
   task automatic measure();
      int n;
      n = 0;
      len = 0;
      @(posedge pclk);
      while (osc_pin_o !== 1'b0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      while (osc_pin_o !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      while (n < 100 && osc_pin_o === 1'b1 && len < 600) begin
         @(posedge pclk);
         len++;
      end
   endtask : measure

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end

   // ********************
   // tests
   // ********************
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc(CTRL_OFFSET, 32'h0000_0000);
      rdc(CLKW_OFFSET, 32'h0000_0000);
      rdc(INC_OFFSET, 32'h0000_0000);
      rdc(12'h00C, 32'h0000_0000);
      chk(er, 1'b1);
      apb(1'b1, CLKW_OFFSET, 32'h0000_00FF);
      rdc(CLKW_OFFSET, 32'h0000_00E3);
      apb(1'b1, CTRL_OFFSET, 32'h0000_00FF);
      rdc(CTRL_OFFSET, 32'h0000_00F1);
      chk(pin_level, 1'b1);
      apb(1'b1, CTRL_OFFSET, 32'h0000_00A1);
      rdc(CTRL_OFFSET, 32'h0000_0081);
      chk(osc_pin_o, 1'b0);
      apb(1'b1, CTRL_OFFSET, 32'h0000_0091);
      repeat (2) @(posedge pclk);
      chk(osc_pin_o, 1'b1);
      chk({osc_pin_oe, pin_level}, 2'h0);
      // each source alone drives the oscillator, width ignored
      apb(1'b1, INC_OFFSET, 32'h0000_8000);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
         mask <= ~(4'h1 << s);
         apb(1'b1, CLKW_OFFSET, {24'h0, 3'h3, 3'h0, s[1:0]});
         apb(1'b1, CTRL_OFFSET, 32'h0000_00C0);
         measure();
         chk(len, 32'h0000_0000);
         mask <= 4'h1 << s;
         measure();
         chk(len, 32'h0000_0008);
      end
      apb(1'b1, CTRL_OFFSET, 32'h0000_0040);
      measure();
      chk(len, 32'h0000_0000);
      // pulse mode, width kept below the 16-tick overflow
      mask <= 4'h2;
      apb(1'b1, INC_OFFSET, 32'h0000_1000);
      for (int w = 0; w < 4; w++) begin
         apb(1'b1, CLKW_OFFSET, {24'h0, w[2:0], 3'h0, 2'h1});
         apb(1'b1, CTRL_OFFSET, 32'h0000_00C1);
         measure();
         chk(len, 32'h4 << w);
      end
      conclude();
   end
endmodule : nco_control_output_tb
`default_nettype wire
